// [tw_pkg.sv]
// Package for the two-wire bus interface: register map, field layout, timing table
// Notes on behaviour
// - Rates up to clock/20; 100 kbps fully loaded.
// - Pin select bit picks pin pair, default zero.
// - Keeps running in wait mode; event output wakes.
// - Shallow stop freezes; deep stop resets all registers.
// - Own address occupies address register bits 7..1.
// - Bits 7..6 pick multiplier 1, 2 or 4.
// - Bits 5..0 index 64 divider/hold combinations.
// - Bit rate is clock over multiplier times divider.
// - Data changes hold time after clock falls.
// - Start: clock falls start-hold after data falls.
// - Stop: data rises stop-hold after clock rises.
// - Arbitration loss flags event, drops to slave.
// - Own address match flags an event.
// - Generates and detects start, stop, repeated start.
// - Generates and detects acknowledge; software selects ack.
// - Byte-wise transfer, event after every byte.
// - Recognises general call and 10-bit addressing.
// - Both lines open-drain, only ever pulled low.
// - Index maps through fixed divider and hold table.
package tw_pkg;

  // Register word indices
  localparam logic [2:0] TW_REG_ADDR = 3'h0;
  localparam logic [2:0] TW_REG_RATE = 3'h1;
  localparam logic [2:0] TW_REG_CTRL = 3'h2;
  localparam logic [2:0] TW_REG_STAT = 3'h3;
  localparam logic [2:0] TW_REG_DATA = 3'h4;
  localparam logic [2:0] TW_REG_OPT = 3'h5;

  // Control bits
  localparam int TW_CTRL_EN = 7;
  localparam int TW_CTRL_IE = 6;
  localparam int TW_CTRL_MST = 5;
  localparam int TW_CTRL_TX = 4;
  localparam int TW_CTRL_TXAK = 3;
  localparam int TW_CTRL_RSTA = 2;

  // Status bits
  localparam int TW_STAT_TCF = 7;
  localparam int TW_STAT_AAS = 6;
  localparam int TW_STAT_BUSY = 5;
  localparam int TW_STAT_ARBL = 4;
  localparam int TW_STAT_SRW = 2;
  localparam int TW_STAT_IF = 1;
  localparam int TW_STAT_RXAK = 0;

  // Option bits
  localparam int TW_OPT_PSEL = 7;
  localparam int TW_OPT_GCAEN = 6;
  localparam int TW_OPT_ADEXT = 5;

  localparam logic [7:0] TW_RESET_BYTE = 8'h00;
  localparam logic [4:0] TW_TEN_BIT_PREFIX = 5'h1e;
  // Cycles between a clock fall on the line and the data change decision reaching the pad
  localparam logic [15:0] TW_HOLD_LAG = 16'h0005;

  // Divider and hold values for index groups 0..3; higher groups scale from group 3
  localparam logic [7:0] TW_DIV_BASE [32] = '{
    8'd20, 8'd22, 8'd24, 8'd26, 8'd28, 8'd30, 8'd34, 8'd40,
    8'd28, 8'd32, 8'd36, 8'd40, 8'd44, 8'd48, 8'd56, 8'd68,
    8'd48, 8'd56, 8'd64, 8'd72, 8'd80, 8'd88, 8'd104, 8'd128,
    8'd80, 8'd96, 8'd112, 8'd128, 8'd144, 8'd160, 8'd192, 8'd240};
  localparam logic [7:0] TW_SDA_BASE [32] = '{
    8'd7, 8'd7, 8'd8, 8'd8, 8'd9, 8'd9, 8'd10, 8'd10,
    8'd7, 8'd7, 8'd9, 8'd9, 8'd11, 8'd11, 8'd13, 8'd13,
    8'd9, 8'd9, 8'd13, 8'd13, 8'd17, 8'd17, 8'd21, 8'd21,
    8'd9, 8'd9, 8'd17, 8'd17, 8'd25, 8'd25, 8'd33, 8'd33};
  localparam logic [7:0] TW_STA_BASE [32] = '{
    8'd6, 8'd7, 8'd8, 8'd9, 8'd10, 8'd11, 8'd13, 8'd16,
    8'd10, 8'd12, 8'd14, 8'd16, 8'd18, 8'd20, 8'd24, 8'd30,
    8'd18, 8'd22, 8'd26, 8'd30, 8'd34, 8'd38, 8'd46, 8'd58,
    8'd38, 8'd46, 8'd54, 8'd62, 8'd70, 8'd78, 8'd94, 8'd118};
  localparam logic [7:0] TW_STO_BASE [32] = '{
    8'd11, 8'd12, 8'd13, 8'd14, 8'd15, 8'd16, 8'd18, 8'd21,
    8'd15, 8'd17, 8'd19, 8'd21, 8'd23, 8'd25, 8'd29, 8'd35,
    8'd25, 8'd29, 8'd33, 8'd37, 8'd41, 8'd45, 8'd53, 8'd65,
    8'd41, 8'd49, 8'd57, 8'd65, 8'd73, 8'd81, 8'd97, 8'd121};

  typedef struct packed {
    logic [11:0] div;
    logic [11:0] sda;
    logic [11:0] sta;
    logic [11:0] sto;
  } tw_timing_type;

  typedef struct packed {
    logic scl_o;
    logic scl_oe_n;
    logic sda_o;
    logic sda_oe_n;
  } tw_pad_type;

  typedef enum logic [2:0] {
    TW_M_IDLE = 3'b000,
    TW_M_START = 3'b001,
    TW_M_LOW = 3'b010,
    TW_M_HIGH = 3'b011,
    TW_M_STOP_L = 3'b100,
    TW_M_STOP_H = 3'b101,
    TW_M_RSTA_L = 3'b110,
    TW_M_RSTA_H = 3'b111
  } tw_mstate_type;

  function automatic tw_timing_type tw_timing(input logic [5:0] idx);
    tw_timing_type t;
    logic [4:0] row;
    logic [2:0] k;
    row = (idx[5:3] < 3'h4) ? idx[4:0] : {2'b11, idx[2:0]};
    k = (idx[5:3] < 3'h4) ? 3'h0 : 3'(idx[5:3] - 3'h3);
    if (k == 3'h0) begin
      t.div = {4'h0, TW_DIV_BASE[row]};
      t.sda = {4'h0, TW_SDA_BASE[row]};
      t.sta = {4'h0, TW_STA_BASE[row]};
      t.sto = {4'h0, TW_STO_BASE[row]};
    end else begin
      t.div = 12'({4'h0, TW_DIV_BASE[row]} << k);
      t.sda = 12'(({4'h0, TW_SDA_BASE[row]} - 12'h001) << k) + 12'h001;
      t.sta = 12'(({4'h0, TW_STA_BASE[row]} + 12'h002) << k) - 12'h002;
      t.sto = 12'(({4'h0, TW_STO_BASE[row]} - 12'h001) << k) + 12'h001;
    end
    return t;
  endfunction

endpackage

// [tw_bus_ctrl.sv]
// Two-wire bus controller with Avalon-MM register slave
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tw_bus_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Power modes
  input wire logic wait_mode,
  input wire logic stop_shallow,
  input wire logic stop_deep,
  // Avalon-MM slave
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Event request
  output logic bus_event_irq,
  // Pin pair A
  input wire logic scl_a_i,
  input wire logic sda_a_i,
  output tw_pkg::tw_pad_type pads_a,
  // Pin pair B
  input wire logic scl_b_i,
  input wire logic sda_b_i,
  output tw_pkg::tw_pad_type pads_b
);
  import tw_pkg::*;

  logic rst;
  logic ack_q, acc, wr_en;
  logic [7:0] wdata;
  logic [7:0] ad_q, rate_q, opt_q;
  logic en_q, ie_q, mst_q, tx_q, txak_q;
  logic tcf_q, aas_q, busy_q, arbl_q, srw_q, if_q, rxak_q;
  logic [3:0] sync1_q, sync2_q;
  logic scl_s, sda_s, scl_p_q, sda_p_q;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, next_bit_sh;
  logic addr_phase_q, ten_pend_q, ten_seen_q, hold_q, sda_data_q;
  logic dly_pend_q, next_q, skip_q;
  logic [15:0] dly_q, m_cnt_q;
  tw_mstate_type m_state_q;
  logic stop_pend_q, rsta_pend_q;
  tw_timing_type tim;
  logic [1:0] msh;
  logic [15:0] div_cyc, half_cyc, sda_cyc, sta_cyc, sto_cyc;
  logic wr_ctrl, wr_stat, wr_data, rd_data;
  logic start_req, start_busy, stop_req, rsta_req;
  logic involved, arb_loss, byte_done, gc_hit, own_hit, ten_first, ten_low, hit, hit_rd;
  logic pull_scl, pull_sda, psel;
  logic unused_wait;

  // Deep stop wipes every register just like a reset
  assign rst = sys_rst | stop_deep;
  // Wait mode needs nothing: the engine keeps its clock and the event output wakes the core
  assign unused_wait = wait_mode;

  // Avalon: one wait cycle, effect and data at the edge where waitrequest is low
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign acc = (avs_read | avs_write) & ack_q;
  assign wr_en = acc & avs_write & avs_byteenable[0];
  assign wdata = avs_writedata[7:0];
  assign wr_ctrl = wr_en & (avs_address == TW_REG_CTRL);
  assign wr_stat = wr_en & (avs_address == TW_REG_STAT);
  assign wr_data = wr_en & (avs_address == TW_REG_DATA);
  assign rd_data = acc & avs_read & (avs_address == TW_REG_DATA);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack_q) begin
      unique case (avs_address)
        TW_REG_ADDR: avs_readdata <= {24'h00_0000, ad_q[7:1], 1'b0};
        TW_REG_RATE: avs_readdata <= {24'h00_0000,
          (rate_q[7:6] == 2'b11) ? 2'b00 : rate_q[7:6], rate_q[5:0]};
        TW_REG_CTRL: avs_readdata <= {24'h00_0000, en_q, ie_q, mst_q, tx_q, txak_q, 3'h0};
        TW_REG_STAT: avs_readdata <= {24'h00_0000, tcf_q, aas_q, busy_q, arbl_q, 1'b0,
          srw_q, if_q, rxak_q};
        TW_REG_DATA: avs_readdata <= {24'h00_0000, sh_q};
        TW_REG_OPT: avs_readdata <= {24'h00_0000, opt_q};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Address, rate and option registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ad_q <= TW_RESET_BYTE;
      rate_q <= TW_RESET_BYTE;
      opt_q <= TW_RESET_BYTE;
    end else begin
      if (wr_en & (avs_address == TW_REG_ADDR)) begin
        ad_q <= {wdata[7:1], 1'b0};
      end
      if (wr_en & (avs_address == TW_REG_RATE)) begin
        rate_q <= wdata;
      end
      if (wr_en & (avs_address == TW_REG_OPT)) begin
        opt_q <= {wdata[7:5], 2'b00, wdata[2:0]};
      end
    end
  end

  // Timing from the index table, scaled by the multiplier (code 3 acts as 4)
  always_comb begin
    tim = tw_timing(rate_q[5:0]);
    msh = (rate_q[7:6] == 2'b11) ? 2'b10 : rate_q[7:6];
    div_cyc = {4'h0, tim.div} << msh;
    half_cyc = div_cyc >> 1;
    sda_cyc = {4'h0, tim.sda} << msh;
    sta_cyc = {4'h0, tim.sta} << msh;
    sto_cyc = {4'h0, tim.sto} << msh;
  end

  // Pin inputs pass two flops, then the selected pair is used
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_q <= 4'hf;
      sync2_q <= 4'hf;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      sync1_q <= {sda_b_i, scl_b_i, sda_a_i, scl_a_i};
      sync2_q <= sync1_q;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign psel = opt_q[TW_OPT_PSEL];
  assign scl_s = psel ? sync2_q[2] : sync2_q[0];
  assign sda_s = psel ? sync2_q[3] : sync2_q[1];
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // Bus events seen by the byte engine
  always_comb begin
    involved = en_q & (mst_q | aas_q | ten_pend_q);
    start_req = wr_ctrl & wdata[TW_CTRL_MST] & ~mst_q & ~busy_q;
    start_busy = wr_ctrl & wdata[TW_CTRL_MST] & ~mst_q & busy_q;
    stop_req = wr_ctrl & ~wdata[TW_CTRL_MST] & mst_q;
    rsta_req = wr_ctrl & wdata[TW_CTRL_RSTA] & mst_q;
    arb_loss = start_busy | (en_q & mst_q & tx_q & scl_rise & (cnt_q < 4'h8) & sda_data_q &
      ~sda_s & ((m_state_q == TW_M_LOW) | (m_state_q == TW_M_HIGH)));
    byte_done = en_q & scl_fall & (cnt_q == 4'h8) & (mst_q | aas_q);
    gc_hit = opt_q[TW_OPT_GCAEN] & (sh_q == 8'h00);
    own_hit = ~opt_q[TW_OPT_ADEXT] & (sh_q[7:1] == ad_q[7:1]);
    ten_first = opt_q[TW_OPT_ADEXT] & (sh_q[7:1] == {TW_TEN_BIT_PREFIX, opt_q[2:1]});
    ten_low = opt_q[TW_OPT_ADEXT] & ten_pend_q & (sh_q == {opt_q[0], ad_q[7:1]});
    hit = en_q & ~mst_q & addr_phase_q & scl_fall & (cnt_q == 4'h7) &
      (gc_hit | own_hit | ten_low | (ten_first & sh_q[0] & ten_seen_q));
    hit_rd = ~gc_hit & sh_q[0] & (own_hit | ten_first);
    next_bit_sh = sh_q;
  end

  // Control register; arbitration loss drops master mode, a read address sets transmit
  always_ff @(posedge core_clk) begin
    if (rst) begin
      en_q <= 1'b0;
      ie_q <= 1'b0;
      mst_q <= 1'b0;
      tx_q <= 1'b0;
      txak_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        en_q <= wdata[TW_CTRL_EN];
        ie_q <= wdata[TW_CTRL_IE];
        mst_q <= wdata[TW_CTRL_MST] & ~busy_q;
        tx_q <= wdata[TW_CTRL_TX];
        txak_q <= wdata[TW_CTRL_TXAK];
      end
      if (hit) begin
        tx_q <= hit_rd;
      end
      if (arb_loss) begin
        mst_q <= 1'b0;
      end
    end
  end

  // Sticky flags, write one to clear; a set in the same cycle wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      if_q <= 1'b0;
      arbl_q <= 1'b0;
    end else if (~stop_shallow) begin
      if (wr_stat & wdata[TW_STAT_IF]) begin
        if_q <= 1'b0;
      end
      if (wr_stat & wdata[TW_STAT_ARBL]) begin
        arbl_q <= 1'b0;
      end
      if (byte_done | hit | arb_loss) begin
        if_q <= 1'b1;
      end
      if (arb_loss) begin
        arbl_q <= 1'b1;
      end
    end
  end

  assign bus_event_irq = if_q & ie_q;

  // Byte engine: shifts on clock rise, drives data a hold time after clock fall
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= 4'h0;
      sh_q <= TW_RESET_BYTE;
      addr_phase_q <= 1'b0;
      ten_pend_q <= 1'b0;
      ten_seen_q <= 1'b0;
      aas_q <= 1'b0;
      srw_q <= 1'b0;
      tcf_q <= 1'b0;
      rxak_q <= 1'b0;
      busy_q <= 1'b0;
      hold_q <= 1'b0;
      sda_data_q <= 1'b1;
      dly_pend_q <= 1'b0;
      dly_q <= 16'h0000;
      next_q <= 1'b1;
      skip_q <= 1'b0;
    end else if (~stop_shallow) begin
      if (dly_pend_q) begin
        if (dly_q == 16'h0000) begin
          sda_data_q <= next_q;
          dly_pend_q <= 1'b0;
        end else begin
          dly_q <= dly_q - 16'h0001;
        end
      end
      if (wr_data) begin
        sh_q <= wdata;
        hold_q <= 1'b0;
        tcf_q <= 1'b0;
        if (tx_q & (cnt_q == 4'h0)) begin
          sda_data_q <= wdata[7];
        end
      end
      if (rd_data & ~tx_q) begin
        hold_q <= 1'b0;
        tcf_q <= 1'b0;
      end
      if (scl_rise & en_q) begin
        if (cnt_q < 4'h8) begin
          sh_q <= {sh_q[6:0], sda_s};
        end else begin
          rxak_q <= sda_s;
        end
      end
      // The first clock fall after a start opens no bit
      if (scl_fall) begin
        skip_q <= 1'b0;
      end
      if (scl_fall & en_q & ~skip_q) begin
        // Hold runs from the line fall; sync, edge detect and pad flops take their share
        dly_q <= (sda_cyc > TW_HOLD_LAG) ? sda_cyc - TW_HOLD_LAG : 16'h0000;
        dly_pend_q <= 1'b1;
        if (cnt_q == 4'h8) begin
          cnt_q <= 4'h0;
          next_q <= 1'b1;
          addr_phase_q <= addr_phase_q & ten_pend_q;
          if (mst_q | aas_q) begin
            tcf_q <= 1'b1;
            hold_q <= 1'b1;
          end
        end else if (cnt_q == 4'h7) begin
          cnt_q <= 4'h8;
          if (addr_phase_q & ~mst_q) begin
            next_q <= ~(hit | (ten_first & ~sh_q[0] & en_q));
          end else if (involved) begin
            next_q <= tx_q | txak_q;
          end else begin
            next_q <= 1'b1;
          end
          if (hit) begin
            aas_q <= 1'b1;
            srw_q <= hit_rd;
            ten_pend_q <= 1'b0;
          end else if (addr_phase_q & ~mst_q & ten_first & ~sh_q[0]) begin
            ten_pend_q <= 1'b1;
            ten_seen_q <= 1'b1;
          end
        end else begin
          cnt_q <= cnt_q + 4'h1;
          next_q <= (involved & tx_q) ? next_bit_sh[7] : 1'b1;
        end
      end
      if (arb_loss) begin
        sda_data_q <= 1'b1;
        dly_pend_q <= 1'b0;
        hold_q <= 1'b0;
      end
      if (start_det) begin
        busy_q <= 1'b1;
        cnt_q <= 4'h0;
        addr_phase_q <= 1'b1;
        aas_q <= 1'b0;
        ten_pend_q <= 1'b0;
        hold_q <= mst_q;
        skip_q <= 1'b1;
        // Own master keeps data low so it never rises under a falling clock
        sda_data_q <= ~mst_q;
        dly_pend_q <= 1'b0;
      end
      if (stop_det) begin
        busy_q <= 1'b0;
        cnt_q <= 4'h0;
        addr_phase_q <= 1'b0;
        aas_q <= 1'b0;
        ten_pend_q <= 1'b0;
        ten_seen_q <= 1'b0;
        hold_q <= 1'b0;
        sda_data_q <= 1'b1;
        dly_pend_q <= 1'b0;
      end
    end
  end

  // Master clock generator; the high phase waits for a stretching slave
  always_ff @(posedge core_clk) begin
    if (rst) begin
      m_state_q <= TW_M_IDLE;
      m_cnt_q <= 16'h0000;
      stop_pend_q <= 1'b0;
      rsta_pend_q <= 1'b0;
    end else if (~stop_shallow) begin
      if (stop_req) begin
        stop_pend_q <= 1'b1;
      end
      if (rsta_req) begin
        rsta_pend_q <= 1'b1;
      end
      if (m_cnt_q != 16'h0000) begin
        m_cnt_q <= m_cnt_q - 16'h0001;
      end
      // Enable may arrive in the same write as the start request
      if (arb_loss | (~en_q & ~start_req)) begin
        m_state_q <= TW_M_IDLE;
        stop_pend_q <= 1'b0;
        rsta_pend_q <= 1'b0;
      end else begin
        unique case (m_state_q)
          TW_M_IDLE: begin
            if (start_req & wdata[TW_CTRL_EN]) begin
              m_state_q <= TW_M_START;
              m_cnt_q <= sta_cyc - 16'h0001;
            end
          end
          TW_M_START: begin
            if (m_cnt_q == 16'h0000) begin
              m_state_q <= TW_M_LOW;
              m_cnt_q <= half_cyc - 16'h0001;
            end
          end
          TW_M_LOW: begin
            if (m_cnt_q == 16'h0000) begin
              if (hold_q & stop_pend_q) begin
                m_state_q <= TW_M_STOP_L;
                m_cnt_q <= half_cyc - 16'h0001;
              end else if (hold_q & rsta_pend_q) begin
                m_state_q <= TW_M_RSTA_L;
                m_cnt_q <= half_cyc - 16'h0001;
              end else if (~hold_q) begin
                m_state_q <= TW_M_HIGH;
                m_cnt_q <= half_cyc - 16'h0001;
              end
            end
          end
          TW_M_HIGH: begin
            if ((m_cnt_q == 16'h0000) & scl_s) begin
              m_state_q <= TW_M_LOW;
              m_cnt_q <= half_cyc - 16'h0001;
            end
          end
          TW_M_STOP_L: begin
            if (m_cnt_q == 16'h0000) begin
              m_state_q <= TW_M_STOP_H;
              m_cnt_q <= sto_cyc - 16'h0001;
            end
          end
          TW_M_STOP_H: begin
            if (m_cnt_q == 16'h0000) begin
              m_state_q <= TW_M_IDLE;
              stop_pend_q <= 1'b0;
            end
          end
          TW_M_RSTA_L: begin
            if (m_cnt_q == 16'h0000) begin
              m_state_q <= TW_M_RSTA_H;
              m_cnt_q <= half_cyc - 16'h0001;
            end
          end
          TW_M_RSTA_H: begin
            if ((m_cnt_q == 16'h0000) & scl_s) begin
              m_state_q <= TW_M_START;
              m_cnt_q <= sta_cyc - 16'h0001;
              rsta_pend_q <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // Line pull-downs; a slave holds the clock low until its byte is serviced
  always_comb begin
    pull_scl = (m_state_q == TW_M_LOW) | (m_state_q == TW_M_STOP_L) |
      (m_state_q == TW_M_RSTA_L) | (en_q & aas_q & ~mst_q & hold_q);
    pull_sda = (m_state_q == TW_M_START) | (m_state_q == TW_M_STOP_L) |
      (m_state_q == TW_M_STOP_H) | (en_q & ~sda_data_q & (m_state_q != TW_M_RSTA_L) &
      (m_state_q != TW_M_RSTA_H));
  end

  // Open drain: output level fixed low, enable active low only while pulling
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pads_a <= '{scl_o: 1'b0, scl_oe_n: 1'b1, sda_o: 1'b0, sda_oe_n: 1'b1};
      pads_b <= '{scl_o: 1'b0, scl_oe_n: 1'b1, sda_o: 1'b0, sda_oe_n: 1'b1};
    end else begin
      pads_a.scl_oe_n <= ~(pull_scl & ~psel);
      pads_a.sda_oe_n <= ~(pull_sda & ~psel);
      pads_b.scl_oe_n <= ~(pull_scl & psel);
      pads_b.sda_oe_n <= ~(pull_sda & psel);
      pads_a.scl_o <= 1'b0;
      pads_a.sda_o <= 1'b0;
      pads_b.scl_o <= 1'b0;
      pads_b.sda_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [tw_bus_ctrl_monitor.sv]
// Assertion checker for the two-wire bus controller
`timescale 1ns/1ps
`default_nettype none
module tw_bus_ctrl_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic stop_deep,
  // Register bus
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Pads
  input wire tw_pkg::tw_pad_type pads_a,
  input wire tw_pkg::tw_pad_type pads_b
);
  import tw_pkg::*;
  logic [7:0] rate_q;
  logic [11:0] hcnt_q;
  logic strt_q;
  logic [11:0] m;
  logic rd_ok;
  assign m = 12'h001 << ((rate_q[7:6] == 2'b11) ? 2'd2 : rate_q[7:6]);
  assign rd_ok = avs_read && !avs_waitrequest;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Shadow of the rate byte; timing is only judged at index 0 to keep the table out
  always_ff @(posedge core_clk) begin
    if (sys_rst || stop_deep) begin
      rate_q <= 8'h00;
    end else if (avs_write && !avs_waitrequest && avs_byteenable[0] &&
        avs_address == TW_REG_RATE) begin
      rate_q <= avs_writedata[7:0];
    end
  end
  // Cycles with data pulled and clock released
  always_ff @(posedge core_clk) begin
    if (sys_rst || pads_a.sda_oe_n || !pads_a.scl_oe_n) begin
      hcnt_q <= 12'h000;
    end else begin
      hcnt_q <= hcnt_q + 12'h001;
    end
  end
  // Marks a data fall under a released clock, so data-zero bits are not taken for starts
  always_ff @(posedge core_clk) begin
    if (sys_rst || !pads_a.scl_oe_n) begin
      strt_q <= 1'b0;
    end else if ($fell(pads_a.sda_oe_n)) begin
      strt_q <= 1'b1;
    end
  end
  a_deep_release: assert property (stop_deep |=> pads_a.scl_oe_n && pads_a.sda_oe_n &&
    pads_b.scl_oe_n && pads_b.sda_oe_n)
    else $error("pads pulled after deep stop");
  a_single_wait: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus wait not one cycle");
  a_unmapped_zero: assert property (rd_ok && avs_address[2:1] == 2'b11 |->
    avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_addr_low_bit: assert property (rd_ok && avs_address == TW_REG_ADDR |->
    avs_readdata[0] == 1'b0)
    else $error("address bit 0 not zero");
  a_no_drive_high: assert property (!pads_a.scl_o && !pads_a.sda_o &&
    !pads_b.scl_o && !pads_b.sda_o)
    else $error("pad drives high");
  a_one_pair: assert property (!(pads_a.scl_oe_n && pads_a.sda_oe_n) |->
    pads_b.scl_oe_n && pads_b.sda_oe_n)
    else $error("both pairs pulled");
  a_start_hold: assert property ($fell(pads_a.scl_oe_n) && strt_q &&
    rate_q[5:0] == 6'h00 |-> hcnt_q == 12'd6 * m)
    else $error("start hold wrong");
  a_stop_hold: assert property ($rose(pads_a.sda_oe_n) && pads_a.scl_oe_n &&
    rate_q[5:0] == 6'h00 |-> hcnt_q == 12'd11 * m)
    else $error("stop hold wrong");
endmodule
bind tw_bus_ctrl tw_bus_ctrl_monitor u_mon (.core_clk(core_clk), .sys_rst(sys_rst),
  .stop_deep(stop_deep), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pads_a(pads_a),
  .pads_b(pads_b));
`default_nettype wire

// [tw_far_end.sv]
// Far-side model: pull-ups, an acknowledging slave and bit capture
`timescale 1ns/1ps
`default_nettype none
module tw_far_end (
  // Control
  input wire logic ack_en,
  // Pads
  input wire tw_pkg::tw_pad_type pads_a,
  input wire tw_pkg::tw_pad_type pads_b,
  // Line levels and capture
  output logic scl_a,
  output logic sda_a,
  output logic scl_b,
  output logic sda_b,
  output logic [8:0] rx_bits
);
  int nfall;
  logic ack_q;
  // Released lines float high through the pull-ups; nobody drives high
  assign scl_a = pads_a.scl_oe_n;
  assign sda_a = pads_a.sda_oe_n && !ack_q;
  assign scl_b = pads_b.scl_oe_n;
  assign sda_b = pads_b.sda_oe_n;
  initial begin
    nfall = 0;
    ack_q = 1'b0;
    rx_bits = 9'h000;
  end
  always @(negedge sda_a) begin
    if (scl_a === 1'b1) begin
      nfall = 0;
    end
  end
  // Ack held from the eighth bit's fall to the ninth's
  always @(negedge scl_a) begin
    nfall = nfall + 1;
    ack_q = ack_en && (nfall % 9 == 0);
  end
  always @(posedge scl_a) begin
    rx_bits = {rx_bits[7:0], sda_a};
  end
endmodule
`default_nettype wire

// [tw_bus_ctrl_bench.sv]
// Self-checking bench for the two-wire bus controller
`timescale 1ns/1ps
`default_nettype none
module tw_bus_ctrl_bench;
  import tw_pkg::*;
  logic core_clk, sys_rst, wait_mode, stop_shallow, stop_deep, avs_read, avs_write, ack_en;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest, bus_event_irq, scl_a, sda_a, scl_b, sda_b;
  logic [8:0] rx_bits;
  logic [7:0] q;
  tw_pad_type pads_a, pads_b;
  int n_fail, samples_checked, n;
  tw_bus_ctrl u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .wait_mode(wait_mode),
    .stop_shallow(stop_shallow), .stop_deep(stop_deep), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bus_event_irq(bus_event_irq), .scl_a_i(scl_a),
    .sda_a_i(sda_a), .pads_a(pads_a), .scl_b_i(scl_b), .sda_b_i(sda_b), .pads_b(pads_b));
  tw_far_end u_far (.ack_en(ack_en), .pads_a(pads_a), .pads_b(pads_b), .scl_a(scl_a),
    .sda_a(sda_a), .scl_b(scl_b), .sda_b(sda_b), .rx_bits(rx_bits));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One bus cycle; request held until waitrequest is seen low at a rising edge
  task automatic acc(input logic wr, input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge core_clk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    n_fail = 0;
    samples_checked = 0;
    {sys_rst, ack_en} = 2'b11;
    {wait_mode, stop_shallow, stop_deep, avs_read, avs_write} = 5'h00;
    avs_address = 3'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    acc(1'b0, TW_REG_ADDR, 8'h00);
    chk("addr reset", q, TW_RESET_BYTE);
    acc(1'b1, TW_REG_ADDR, 8'hff);
    acc(1'b0, TW_REG_ADDR, 8'h00);
    chk("addr field", q, 8'hfe);
    for (logic [2:0] i = 0; i < 4; i++) begin
      acc(1'b1, TW_REG_RATE, {i[1:0], 6'h2a});
      acc(1'b0, TW_REG_RATE, 8'h00);
      chk("rate", q, {(i == 3) ? 2'b00 : i[1:0], 6'h2a});
    end
    acc(1'b1, 3'h7, 8'h55);
    acc(1'b0, 3'h7, 8'h00);
    chk("unmapped", q, 8'h00);
    avs_byteenable <= 4'h0;
    acc(1'b1, TW_REG_ADDR, 8'h10);
    avs_byteenable <= 4'h1;
    acc(1'b0, TW_REG_ADDR, 8'h00);
    chk("lane off", q, 8'hfe);
    $display("test registers done");
    // Second pass doubles the rate multiplier, withholds the ack and sits in wait mode
    for (int t = 0; t < 2; t++) begin
      ack_en <= (t == 0);
      wait_mode <= (t == 1);
      acc(1'b1, TW_REG_RATE, (t == 0) ? 8'h00 : 8'h40);
      acc(1'b1, TW_REG_CTRL, 8'hf0);
      for (n = 0; n < 300 && scl_a !== 1'b0; n++) @(posedge core_clk);
      acc(1'b1, TW_REG_DATA, 8'h5a);
      q = 8'h00;
      for (n = 0; n < 400 && q[1] !== 1'b1; n++) acc(1'b0, TW_REG_STAT, 8'h00);
      chk("status", q, (t == 0) ? 8'ha2 : 8'ha3);
      chk("wire byte", rx_bits[8:1], 8'h5a);
      chk("ack bit", {7'h0, rx_bits[0]}, (t == 0) ? 8'h00 : 8'h01);
      chk("event", {7'h0, bus_event_irq}, 8'h01);
      acc(1'b1, TW_REG_STAT, 8'h02);
      @(negedge core_clk);
      chk("event clear", {7'h0, bus_event_irq}, 8'h00);
      acc(1'b1, TW_REG_CTRL, 8'hc0);
      q = 8'hff;
      for (n = 0; n < 300 && q[5] !== 1'b0; n++) acc(1'b0, TW_REG_STAT, 8'h00);
      chk("idle", q[5:4], 8'h00);
      $display("test transfer done");
    end
    @(posedge core_clk);
    stop_deep <= 1'b1;
    @(posedge core_clk);
    stop_deep <= 1'b0;
    acc(1'b0, TW_REG_ADDR, 8'h00);
    chk("deep stop", q, 8'h00);
    $display("test deep stop done");
    report_and_stop();
  end
endmodule
`default_nettype wire
